// >>> hw/idc_controller.sv
// instruction and data cache controllers with their control registers
// Operation
// [RQ1] each cache size chosen independently, 0 to 1M
// [RQ2] direct, 2-way or 4-way; 32-byte lines
// [RQ3] read hit answers in one cycle
// [RQ4] compare all ways; miss goes to memory
// [RQ5] cacheable read miss allocates counter-chosen way; code uses the LFSR unless round robin is set
// [RQ6] lock base limits victim range; none direct
// [RQ7] address split byte, word, index, tag
// [RQ8] 4-way index bits 9..17 top by size
// [RQ9] fewer ways widen index, narrow tag
// [RQ10] tag entry: valid bit 4, dirty 3:2
// [RQ11] valid set on fill, cleared at reset
// [RQ12] dirty only in write-back data regions
// [RQ13] instruction cache reads, fills whole lines
// [RQ14] instruction enable bit 12 needs protection unit
// [RQ15] instruction hit returns only when cacheable
// [RQ16] cacheable miss fills from word zero; else single
// [RQ17] disabled cache: no lookup, single fetches
// [RQ18] reset invalidates instruction cache
// [RQ19] flush with data zero clears all lines
// [RQ20] line flush clears matching line only
// [RQ21] data enable bit 2 needs protection unit
// [RQ22] reset disables and invalidates data cache
// [RQ23] disabled data cache forces noncacheable
// [RQ24] hit word picked by address bits 4:2
`timescale 1ns/100ps

module idc_cache import idc_pkg::*; #(
    parameter int SIZE_KB = 4,
    parameter int WAYS = 4,
    parameter bit IS_DATA = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control from the register file
    input wire logic enable,
    input wire logic roundRobin,
    input wire logic [1:0] lockBase,
    input wire logic flushAll,
    input wire logic flushLine,
    input wire logic [31:0] flushAddr,
    // core request and answer
    input wire logic req,
    input wire logic write,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic cacheable,
    input wire logic bufferable,
    output logic ack,
    output logic [31:0] rdata,
    output logic ready,
    output logic [31:0] lastEntry,
    // external memory side
    output logic memReq,
    output logic memWe,
    output logic [31:0] memAddr,
    output logic [31:0] memWdata,
    output logic memBuf,
    output logic memCach,
    input wire logic memAck,
    input wire logic [31:0] memRdata
);
    // geometry derived from size and ways
    localparam int SETS_RAW = SIZE_KB * 1024 / (LINE_BYTES * WAYS); // see RQ2
    localparam int SETS = (SETS_RAW < 1) ? 1 : SETS_RAW;
    localparam int IW = (SETS > 1) ? $clog2(SETS) : 1;
    localparam int TW = 32 - LINE_LSB - IW;
    localparam int WB = (WAYS > 1) ? $clog2(WAYS) : 1;
    localparam int DW = WB + IW + 3;
    localparam bit PRESENT = (SIZE_KB != 0);

    // whole sequencer state
    typedef struct packed {
        idc_state_t state;
        logic [31:0] addr;
        logic wr;
        logic [2:0] cnt;
        logic [WB-1:0] victim;
        logic [WB-1:0] wayCnt;
        logic [7:0] lfsr;
        logic [WAYS-1:0][SETS-1:0] valid;
        logic [WAYS-1:0][SETS-1:0][1:0] dirty;
        logic ack;
        logic ready;
        logic [31:0] rdata;
        logic memReq;
        logic memWe;
        logic [31:0] memAddr;
        logic [31:0] memWdata;
        logic memBuf;
        logic memCach;
        logic [31:0] lastEntry;
    } idc_cache_st_t;

    idc_cache_st_t r;
    idc_cache_st_t n;
    // tag and data arrays
    logic [TW-1:0] tagMem [WAYS][SETS];
    logic [31:0] dataMem [WAYS*SETS*8];
    // lookup results
    logic [IW-1:0] idx;
    logic [TW-1:0] tagIn;
    logic [IW-1:0] fIdx;
    logic [TW-1:0] fTag;
    logic cEff;
    logic hit;
    logic [WB-1:0] hitWay;
    logic [31:0] hitWord;
    // replacement choice
    logic [WB-1:0] lb;
    logic [WB-1:0] pick;
    logic [WB-1:0] victim;
    // array write strobes
    logic dWe;
    logic [DW-1:0] dIdx;
    logic [31:0] dData;
    logic tWe;

    // address fields
    assign idx = addr[LINE_LSB +: IW]; // see RQ7 see RQ8 see RQ9
    assign tagIn = addr[31 -: TW]; // see RQ7
    assign fIdx = flushAddr[LINE_LSB +: IW];
    assign fTag = flushAddr[31 -: TW];
    // disabled or absent cache is treated as noncacheable
    assign cEff = PRESENT && enable && cacheable; // see RQ1 see RQ15 see RQ17 see RQ23

    // compare every way at the indexed set
    always_comb begin
        hit = 1'b0;
        hitWay = '0;
        hitWord = '0;
        for (int w = 0; w < WAYS; w++) begin
            if (r.valid[w][idx] && tagMem[w][idx] == tagIn) begin // see RQ4 see RQ11
                hit = 1'b1;
                hitWay = WB'(w);
                hitWord = dataMem[{WB'(w), idx, addr[4:2]}]; // see RQ24
            end
        end
    end

    // victim way from round-robin counter or LFSR, kept at or above lock base
    always_comb begin
        lb = '0;
        if (WAYS > 1) begin
            lb = (lockBase > 2'(WAYS - 1)) ? WB'(WAYS - 1) : WB'(lockBase); // see RQ6
        end
        pick = roundRobin ? r.wayCnt : r.lfsr[WB-1:0]; // see RQ5
        victim = (pick < lb) ? lb : pick; // see RQ6
    end

    // next state
    always_comb begin
        n = r;
        n.ack = 1'b0;
        n.lfsr = {r.lfsr[6:0], ~(r.lfsr[7] ^ r.lfsr[5] ^ r.lfsr[4] ^ r.lfsr[3])};
        dWe = 1'b0;
        dIdx = '0;
        dData = '0;
        tWe = 1'b0;
        // flush first, so a fill ending in the same cycle keeps its line
        if (flushAll) begin
            n.valid = '0; // see RQ19
            n.dirty = '0;
        end else if (flushLine) begin
            for (int w = 0; w < WAYS; w++) begin
                if (r.valid[w][fIdx] && tagMem[w][fIdx] == fTag) begin
                    n.valid[w][fIdx] = 1'b0; // see RQ20
                    n.dirty[w][fIdx] = 2'h0;
                end
            end
        end
        case (r.state)
            ST_IDLE: begin
                if (req) begin
                    n.addr = addr;
                    n.wr = write && IS_DATA; // see RQ13
                    n.memCach = cEff;
                    n.memBuf = bufferable; // see RQ23
                    if (!n.wr && cEff && hit) begin
                        // single cycle hit
                        n.ack = 1'b1; // see RQ3
                        n.rdata = hitWord;
                    end else if (!n.wr && cEff) begin
                        // line fill from word zero
                        n.state = ST_FILL; // see RQ5 see RQ16
                        n.victim = victim;
                        n.wayCnt = (victim >= WB'(WAYS - 1)) ? lb : victim + 1'b1;
                        n.cnt = 3'h0;
                        n.memReq = 1'b1;
                        n.memWe = 1'b0;
                        n.memAddr = {addr[31:LINE_LSB], 5'h00};
                    end else if (!n.wr) begin
                        // one external word, cache untouched
                        n.state = ST_SINGLE; // see RQ16 see RQ17
                        n.memReq = 1'b1;
                        n.memWe = 1'b0;
                        n.memAddr = addr;
                    end else begin
                        if (cEff && hit) begin
                            dWe = 1'b1;
                            dIdx = {hitWay, idx, addr[4:2]};
                            dData = wdata;
                            if (bufferable) begin
                                n.dirty[hitWay][idx][addr[4]] = 1'b1; // see RQ12
                            end
                        end
                        if (cEff && hit && bufferable) begin
                            // write-back hit stays inside
                            n.ack = 1'b1; // see RQ4
                        end else begin
                            n.state = ST_WRITE;
                            n.memReq = 1'b1;
                            n.memWe = 1'b1;
                            n.memAddr = addr;
                            n.memWdata = wdata;
                        end
                    end
                end
            end
            ST_FILL: begin
                if (memAck) begin
                    dWe = 1'b1;
                    dIdx = {r.victim, r.addr[LINE_LSB +: IW], r.cnt};
                    dData = memRdata;
                    if (r.cnt == r.addr[4:2]) begin
                        n.rdata = memRdata;
                    end
                    n.cnt = r.cnt + 3'h1;
                    n.memAddr[4:2] = r.cnt + 3'h1;
                    if (r.cnt == 3'h7) begin
                        // last beat: tag, valid, answer
                        tWe = 1'b1;
                        n.valid[r.victim][r.addr[LINE_LSB +: IW]] = 1'b1; // see RQ11
                        n.dirty[r.victim][r.addr[LINE_LSB +: IW]] = 2'h0;
                        n.lastEntry = '0;
                        n.lastEntry[31:LINE_LSB] = r.addr[31:LINE_LSB];
                        n.lastEntry[TAG_VALID_BIT] = 1'b1; // see RQ10
                        n.lastEntry[TAG_SET_LSB +: 2] = 2'(r.victim);
                        n.memReq = 1'b0;
                        n.ack = 1'b1;
                        n.state = ST_IDLE;
                    end
                end
            end
            ST_SINGLE: begin
                if (memAck) begin
                    n.rdata = memRdata;
                    n.memReq = 1'b0;
                    n.ack = 1'b1;
                    n.state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (memAck) begin
                    n.memReq = 1'b0;
                    n.memWe = 1'b0;
                    n.ack = 1'b1;
                    n.state = ST_IDLE;
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase
        n.ready = (n.state == ST_IDLE);
    end

    // state register; reset clears every valid and dirty bit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0; // see RQ18 see RQ22
        end else begin
            r <= n;
        end
    end

    // array writes, no reset needed behind the valid bits
    always_ff @(posedge clk) begin
        if (dWe) begin
            dataMem[dIdx] <= dData;
        end
        if (tWe) begin
            tagMem[r.victim][r.addr[LINE_LSB +: IW]] <= r.addr[31 -: TW];
        end
    end

    // outputs straight from the state register
    assign ack = r.ack;
    assign rdata = r.rdata;
    assign ready = r.ready;
    assign lastEntry = r.lastEntry;
    assign memReq = r.memReq;
    assign memWe = r.memWe;
    assign memAddr = r.memAddr;
    assign memWdata = r.memWdata;
    assign memBuf = r.memBuf;
    assign memCach = r.memCach;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic idleReq;
    logic fillEnd;
    assign idleReq = (r.state == ST_IDLE) && req;
    assign fillEnd = (r.state == ST_FILL) && memAck && r.cnt == 3'h7;

    property p_hit_one_cycle;
        idleReq && !n.wr && cEff && hit |=> ack && r.state == ST_IDLE;
    endproperty
    a_hit_one_cycle: assert property (p_hit_one_cycle) else $error("hit not answered"); // see RQ3
    property p_hit_word;
        idleReq && !n.wr && cEff && hit |=> rdata == $past(hitWord);
    endproperty
    a_hit_word: assert property (p_hit_word) else $error("wrong hit word"); // see RQ24
    property p_miss_fill;
        idleReq && !n.wr && cEff && !hit |=> r.state == ST_FILL && memReq
            && memAddr == {$past(addr[31:LINE_LSB]), 5'h00};
    endproperty
    a_miss_fill: assert property (p_miss_fill) else $error("fill start wrong"); // see RQ16
    property p_lock_victim;
        idleReq && !n.wr && cEff && !hit |=> r.victim >= $past(lb);
    endproperty
    a_lock_victim: assert property (p_lock_victim) else $error("locked way chosen"); // see RQ6
    property p_fill_valid;
        fillEnd |=> ack && r.valid[$past(r.victim)][$past(r.addr[LINE_LSB +: IW])];
    endproperty
    a_fill_valid: assert property (p_fill_valid) else $error("filled line invalid"); // see RQ11
    property p_uncached;
        idleReq && !n.wr && !cEff |=> r.state == ST_SINGLE && memAddr == $past(addr);
    endproperty
    a_uncached: assert property (p_uncached) else $error("single fetch wrong"); // see RQ17
    property p_flush_all;
        flushAll && !fillEnd |=> r.valid == '0;
    endproperty
    a_flush_all: assert property (p_flush_all) else $error("flush left lines"); // see RQ19
    property p_wt_clean;
        idleReq && !(cEff && bufferable) && !flushAll && !flushLine
            |=> r.dirty == $past(r.dirty);
    endproperty
    a_wt_clean: assert property (p_wt_clean) else $error("dirty outside write-back"); // see RQ12
    property p_disabled;
        idleReq && !enable |=> r.state == ST_SINGLE || r.state == ST_WRITE;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled cache used"); // see RQ23

    c_hit: cover property (idleReq && cEff && hit);
    c_fill: cover property (fillEnd);
    c_flush: cover property (flushLine && r.valid != '0);
    c_wb: cover property (idleReq && n.wr && cEff && hit && bufferable);
endmodule

module idc_controller import idc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // instruction fetch port
    input wire logic fetchReq,
    input wire logic [31:0] fetchAddr,
    input wire logic instrCacheableFlag,
    output logic fetchAck,
    output logic [31:0] fetchData,
    output logic fetchReady,
    // load and store port
    input wire logic dataReq,
    input wire logic dataWrite,
    input wire logic [31:0] dataAddr,
    input wire logic [31:0] dataWdata,
    input wire logic dataCacheableFlag,
    input wire logic dataBufferableFlag,
    output logic dataAck,
    output logic [31:0] dataRdata,
    output logic dataReady,
    // instruction external memory
    output logic imemReq,
    output logic [31:0] imemAddr,
    input wire logic imemAck,
    input wire logic [31:0] imemRdata,
    // data external memory
    output logic dmemReq,
    output logic dmemWrite,
    output logic [31:0] dmemAddr,
    output logic [31:0] dmemWdata,
    output logic dmemBufferable,
    output logic dmemCacheable,
    input wire logic dmemAck,
    input wire logic [31:0] dmemRdata
);
    // register file state
    typedef struct packed {
        logic [31:0] ctrl;
        logic [1:0] iLock;
        logic [1:0] dLock;
        logic iFlushAll;
        logic iFlushLine;
        logic dFlushAll;
        logic dFlushLine;
        logic [31:0] flushAddr;
        logic [31:0] rdata;
    } idc_regs_t;

    idc_regs_t r;
    idc_regs_t n;
    logic icOn;
    logic dcOn;
    logic [31:0] iLast;
    logic [31:0] dLast;

    // enables count only with the protection unit on
    assign icOn = r.ctrl[CTRL_IC_EN] && r.ctrl[CTRL_PU_EN]; // see RQ14
    assign dcOn = r.ctrl[CTRL_DC_EN] && r.ctrl[CTRL_PU_EN]; // see RQ21

    // register writes, flush pulses and read data
    always_comb begin
        n = r;
        n.iFlushAll = 1'b0;
        n.iFlushLine = 1'b0;
        n.dFlushAll = 1'b0;
        n.dFlushLine = 1'b0;
        n.rdata = '0;
        if (regWrite) begin
            n.flushAddr = regWdata;
            case (regAddr)
                OFF_CTRL: n.ctrl = regWdata & CTRL_MASK;
                OFF_ILOCK: n.iLock = regWdata[1:0];
                OFF_DLOCK: n.dLock = regWdata[1:0];
                OFF_IFLUSH: n.iFlushAll = (regWdata == FLUSH_ALL_KEY); // see RQ19
                OFF_IFLUSH_LINE: n.iFlushLine = 1'b1; // see RQ20
                OFF_DFLUSH: n.dFlushAll = (regWdata == FLUSH_ALL_KEY);
                OFF_DFLUSH_LINE: n.dFlushLine = 1'b1;
                default: n.flushAddr = r.flushAddr;
            endcase
        end
        if (regRead) begin
            case (regAddr)
                OFF_CTRL: n.rdata = r.ctrl;
                OFF_ILOCK: n.rdata = {30'h0, r.iLock};
                OFF_DLOCK: n.rdata = {30'h0, r.dLock};
                OFF_STATUS: begin
                    n.rdata[STAT_IC_ON] = icOn;
                    n.rdata[STAT_DC_ON] = dcOn;
                    n.rdata[STAT_IC_BUSY] = !fetchReady;
                    n.rdata[STAT_DC_BUSY] = !dataReady;
                end
                OFF_ILAST: n.rdata = iLast;
                OFF_DLAST: n.rdata = dLast;
                default: n.rdata = '0;
            endcase
        end
    end

    // register file flops; reset leaves both caches off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r.ctrl <= CTRL_RST; // see RQ22
            r.iLock <= LOCK_RST;
            r.dLock <= LOCK_RST;
            r.iFlushAll <= 1'b0;
            r.iFlushLine <= 1'b0;
            r.dFlushAll <= 1'b0;
            r.dFlushLine <= 1'b0;
            r.flushAddr <= '0;
            r.rdata <= '0;
        end else begin
            r <= n;
        end
    end

    assign regRdata = r.rdata;

    // instruction cache, read only
    idc_cache #(.SIZE_KB(I_SIZE_KB), .WAYS(I_WAYS), .IS_DATA(1'b0)) u_icache (
        .clk(clk),
        .reset_n(reset_n),
        .enable(icOn),
        .roundRobin(r.ctrl[CTRL_RR]),
        .lockBase(r.iLock),
        .flushAll(r.iFlushAll),
        .flushLine(r.iFlushLine),
        .flushAddr(r.flushAddr),
        .req(fetchReq),
        .write(1'b0),
        .addr(fetchAddr),
        .wdata(32'h0),
        .cacheable(instrCacheableFlag),
        .bufferable(1'b0),
        .ack(fetchAck),
        .rdata(fetchData),
        .ready(fetchReady),
        .lastEntry(iLast),
        .memReq(imemReq),
        .memWe(),
        .memAddr(imemAddr),
        .memWdata(),
        .memBuf(),
        .memCach(),
        .memAck(imemAck),
        .memRdata(imemRdata)
    );

    // data cache
    idc_cache #(.SIZE_KB(D_SIZE_KB), .WAYS(D_WAYS), .IS_DATA(1'b1)) u_dcache (
        .clk(clk),
        .reset_n(reset_n),
        .enable(dcOn),
        .roundRobin(r.ctrl[CTRL_RR]),
        .lockBase(r.dLock),
        .flushAll(r.dFlushAll),
        .flushLine(r.dFlushLine),
        .flushAddr(r.flushAddr),
        .req(dataReq),
        .write(dataWrite),
        .addr(dataAddr),
        .wdata(dataWdata),
        .cacheable(dataCacheableFlag),
        .bufferable(dataBufferableFlag),
        .ack(dataAck),
        .rdata(dataRdata),
        .ready(dataReady),
        .lastEntry(dLast),
        .memReq(dmemReq),
        .memWe(dmemWrite),
        .memAddr(dmemAddr),
        .memWdata(dmemWdata),
        .memBuf(dmemBufferable),
        .memCach(dmemCacheable),
        .memAck(dmemAck),
        .memRdata(dmemRdata)
    );
endmodule

// >>> hw/idc_pkg.sv
// shared constants and types for the instruction and data cache controller
package idc_pkg;
    // cache geometry: size in kbytes (0,4,8,...,1024) and ways (1, 2 or 4)
    localparam int I_SIZE_KB = 4;
    localparam int D_SIZE_KB = 4;
    localparam int I_WAYS = 4;
    localparam int D_WAYS = 4;
    localparam int LINE_BYTES = 32;
    localparam int LINE_LSB = 5;
    // register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ILOCK = 8'h04;
    localparam logic [7:0] OFF_DLOCK = 8'h08;
    localparam logic [7:0] OFF_IFLUSH = 8'h0c;
    localparam logic [7:0] OFF_IFLUSH_LINE = 8'h10;
    localparam logic [7:0] OFF_DFLUSH = 8'h14;
    localparam logic [7:0] OFF_DFLUSH_LINE = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;
    localparam logic [7:0] OFF_ILAST = 8'h20;
    localparam logic [7:0] OFF_DLAST = 8'h24;
    // control register bits
    localparam int CTRL_PU_EN = 0;
    localparam int CTRL_DC_EN = 2;
    localparam int CTRL_IC_EN = 12;
    localparam int CTRL_RR = 14;
    localparam logic [31:0] CTRL_MASK = (32'h1 << CTRL_PU_EN) | (32'h1 << CTRL_DC_EN)
        | (32'h1 << CTRL_IC_EN) | (32'h1 << CTRL_RR);
    localparam logic [31:0] CTRL_RST = 32'h0;
    localparam logic [1:0] LOCK_RST = 2'h0;
    localparam logic [31:0] FLUSH_ALL_KEY = 32'h0;
    // status register bits
    localparam int STAT_IC_ON = 0;
    localparam int STAT_DC_ON = 1;
    localparam int STAT_IC_BUSY = 2;
    localparam int STAT_DC_BUSY = 3;
    // tag entry layout
    localparam int TAG_VALID_BIT = 4;
    localparam int TAG_DIRTY_LSB = 2;
    localparam int TAG_SET_LSB = 0;
    // cache sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_SINGLE, ST_WRITE} idc_state_t;
endpackage

// >>> sim/idc_mem_model.sv
// external memory model answering one cache port word by word
`timescale 1ns/100ps
module idc_mem_model (
    // clock
    input wire logic clk,
    // request from the cache
    input wire logic memReq,
    input wire logic [31:0] memAddr,
    // answer
    output logic memAck,
    output logic [31:0] memRdata
);
    logic [1:0] waitReg = 2'h0; // cycles waited for this word
    initial memAck = 1'b0;
    initial memRdata = 32'h0;
    // latency 0..3 from address bits 3:2; idle data flips every cycle
    always @(posedge clk) begin
        memAck <= 1'b0;
        memRdata <= ~memRdata;
        if (memReq && !memAck) begin
            if (waitReg == memAddr[3:2]) begin
                memAck <= 1'b1;
                memRdata <= {memAddr[31:2], 2'h0} ^ 32'h5a5a_5a5a;
                waitReg <= 2'h0;
            end else begin
                waitReg <= waitReg + 2'h1;
            end
        end
    end
endmodule

// >>> sim/tb_idc_controller.sv
// self-checking bench for the cache controller
`timescale 1ns/100ps
module tb_idc_controller import idc_pkg::*; ();
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr = 8'h0;
    logic [31:0] regWdata = 32'h0, fetchAddr = 32'h0, dataAddr = 32'h0, dataWdata = 32'h0;
    logic regWrite = 1'b0, regRead = 1'b0, fetchReq = 1'b0, instrCacheableFlag = 1'b0;
    logic dataReq = 1'b0, dataWrite = 1'b0, dataCacheableFlag = 1'b0, dataBufferableFlag = 1'b0;
    logic [31:0] regRdata, fetchData, dataRdata, imemAddr, imemRdata;
    logic [31:0] dmemAddr, dmemWdata, dmemRdata;
    logic fetchAck, fetchReady, dataAck, dataReady, imemReq, imemAck, dmemReq, dmemWrite;
    logic dmemBufferable, dmemCacheable, dmemAck, cachSeen = 1'b0;
    int mismatches = 0, checksDone = 0, iAcks = 0, dAcks = 0, cycles = 0;

    idc_controller idc_controller_i (.clk, .reset_n, .regAddr, .regWdata, .regWrite, .regRead,
        .regRdata, .fetchReq, .fetchAddr, .instrCacheableFlag, .fetchAck, .fetchData, .fetchReady,
        .dataReq, .dataWrite, .dataAddr, .dataWdata, .dataCacheableFlag, .dataBufferableFlag,
        .dataAck, .dataRdata, .dataReady, .imemReq, .imemAddr, .imemAck, .imemRdata, .dmemReq,
        .dmemWrite, .dmemAddr, .dmemWdata, .dmemBufferable, .dmemCacheable, .dmemAck, .dmemRdata);
    idc_mem_model imem_model_i (.clk, .memReq(imemReq), .memAddr(imemAddr), .memAck(imemAck),
        .memRdata(imemRdata));
    idc_mem_model dmem_model_i (.clk, .memReq(dmemReq), .memAddr(dmemAddr), .memAck(dmemAck),
        .memRdata(dmemRdata));

    initial forever #4 clk = ~clk;
    // count memory words, watch cacheable marking, cut hangs short
    always @(posedge clk) begin
        iAcks += imemAck;
        dAcks += dmemAck;
        if (dmemReq && dmemCacheable) cachSeen = 1'b1;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[31:2], 2'h0} ^ 32'h5a5a_5a5a;
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic doReset();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic regWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic regRd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        check(what, exp, regRdata);
    endtask
    // one fetch or data access; checks answer, data, memory words, hit latency
    task automatic acc(input bit isD, input bit wr, input logic [31:0] a, input logic cf,
        input int words, input string what);
        int n;
        int start;
        n = 0;
        @(posedge clk);
        start = isD ? dAcks : iAcks;
        if (isD) begin
            dataReq <= 1'b1;
            dataWrite <= wr;
            dataAddr <= a;
            dataWdata <= ~a;
            dataCacheableFlag <= cf;
            dataBufferableFlag <= 1'b1;
        end else begin
            fetchReq <= 1'b1;
            fetchAddr <= a;
            instrCacheableFlag <= cf;
        end
        @(posedge clk);
        fetchReq <= 1'b0;
        dataReq <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (((isD ? dataAck : fetchAck) !== 1'b1) && n < 200);
        check({what, " ack"}, 32'h1, {31'h0, isD ? dataAck : fetchAck});
        if (!wr) check({what, " data"}, pat(a), isD ? dataRdata : fetchData);
        check({what, " words"}, 32'(words), 32'((isD ? dAcks : iAcks) - start));
        if (words == 0) check({what, " cycles"}, 32'h1, 32'(n));
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        doReset();
        regRd(OFF_CTRL, CTRL_RST, "ctrl reset");
        regRd(8'h30, 32'h0, "unmapped");
        regRd(OFF_STATUS, 32'h0, "status reset");
        acc(0, 0, 32'h1004, 1, 1, "fetch off");
        acc(1, 0, 32'h2008, 1, 1, "load off");
        check("cacheable off", 32'h0, {31'h0, cachSeen});
        regWr(OFF_CTRL, 32'h1004);
        acc(0, 0, 32'h1004, 1, 1, "fetch no pu");
        regWr(OFF_CTRL, 32'h5005);
        regRd(OFF_STATUS, 32'h3, "status on");
        $display("test disabled caches done");
        acc(0, 0, 32'h100c, 1, 8, "fetch fill");
        acc(0, 0, 32'h1010, 1, 0, "fetch hit");
        acc(0, 0, 32'h101c, 1, 0, "fetch hit top");
        acc(0, 0, 32'h100c, 0, 1, "hit uncacheable");
        acc(0, 0, 32'h2000, 1, 8, "fill same set");
        acc(0, 0, 32'h1000, 1, 0, "first way kept");
        regWr(OFF_IFLUSH_LINE, 32'h1000);
        acc(0, 0, 32'h2004, 1, 0, "other line kept");
        regWr(OFF_ILOCK, 32'h3);
        acc(0, 0, 32'h1000, 1, 8, "line flushed");
        regRd(OFF_ILAST, 32'h1013, "ilast locked");
        regWr(OFF_IFLUSH, 32'h1);
        acc(0, 0, 32'h1004, 1, 0, "flush key");
        regWr(OFF_IFLUSH, FLUSH_ALL_KEY);
        acc(0, 0, 32'h2000, 1, 8, "flush all");
        $display("test instruction cache done");
        acc(1, 0, 32'h3000, 1, 8, "load fill");
        check("cacheable on", 32'h1, {31'h0, cachSeen});
        regRd(OFF_DLAST, 32'h3010, "dlast");
        acc(1, 0, 32'h3014, 1, 0, "load hit");
        acc(1, 1, 32'h3018, 1, 0, "store wb hit");
        acc(1, 1, 32'h4000, 0, 1, "store miss");
        check("store addr", 32'h4000, dmemAddr);
        check("store data", ~32'h4000, dmemWdata);
        check("store buffered", 32'h1, {31'h0, dmemBufferable});
        regWr(OFF_CTRL, 32'h1001);
        acc(1, 0, 32'h3014, 1, 1, "load disabled");
        $display("test data cache done");
        doReset();
        regRd(OFF_CTRL, CTRL_RST, "ctrl rerun");
        regWr(OFF_CTRL, 32'h1005);
        acc(0, 0, 32'h2000, 1, 8, "fetch after reset");
        acc(1, 0, 32'h3000, 1, 8, "load after reset");
        $display("test reset done");
        final_report();
    end
endmodule
